// File: design/pc_stack_defines.vh
// constants for the program counter and return stack block
`ifndef PC_STACK_DEFINES_VH
`define PC_STACK_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets (haddr[7:0])
// ------------------------------------------------------------
`define OFS_PC_LOW_BYTE      8'h00
`define OFS_PC_HIGH_LATCH    8'h04
`define OFS_PC_UPPER_LATCH   8'h08
`define OFS_STACK_CTL        8'h0c
`define OFS_TOP_ENTRY_LOW    8'h10
`define OFS_TOP_ENTRY_HIGH   8'h14
`define OFS_TOP_ENTRY_UPPER  8'h18

// ------------------------------------------------------------
// stack_pointer_ctl field layout and reset value
// ------------------------------------------------------------
`define FULL_FLAG_BIT        7
`define UNDERFLOW_FLAG_BIT   6
`define LEVEL_MSB            4
`define LEVEL_LSB            0
`define STACK_CTL_RESET      8'h00

// ------------------------------------------------------------
// program counter values
// ------------------------------------------------------------
`define PC_RESET             21'h000000
`define RESET_VECTOR         21'h000000
`define HIGH_PRIO_VECTOR     21'h000008
`define LOW_PRIO_VECTOR      21'h000018
`define PC_STEP              20'h00001

// ------------------------------------------------------------
// stack levels
// ------------------------------------------------------------
`define LEVEL_EMPTY          5'h00
`define LEVEL_BEFORE_FULL    5'h1e
`define LEVEL_TOP            5'h1f
`define LEVEL_STEP           5'h01

// ------------------------------------------------------------
// core operation codes
// ------------------------------------------------------------
`define OP_NONE              4'h0
`define OP_ADVANCE           4'h1
`define OP_JUMP              4'h2
`define OP_CALL              4'h3
`define OP_RETURN            4'h4
`define OP_EXIT_LITERAL      4'h5
`define OP_INTERRUPT_EXIT    4'h6
`define OP_INTERRUPT_ACK     4'h7
`define OP_PUSH              4'h8
`define OP_POP               4'h9

`endif

// File: design/return_stack_store.v
// flip-flop storage of the 31 return stack entries
`timescale 1ns/100ps
`default_nettype none

module return_stack_store (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // write port
    input wire wr_en,
    input wire [4:0] wr_idx,
    input wire [20:0] wr_data,
    // read port
    input wire [4:0] rd_idx,
    output wire [20:0] rd_data
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // level zero has no entry behind it, so the array starts at one
    reg [20:0] entry_q [1:31];
    integer i;

    // write by index; a write at level zero is dropped
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 1; i < 32; i = i + 1) begin
                entry_q[i] <= 21'h000000;
            end
        end else if (wr_en && (wr_idx != 5'h00)) begin
            entry_q[wr_idx] <= wr_data;
        end
    end

    // level zero reads as zero
    assign rd_data = (rd_idx == 5'h00) ? 21'h000000 : entry_q[rd_idx];

endmodule // return_stack_store

`default_nettype wire

// File: design/pc_return_stack.v
// program counter, return stack and fast shadow registers of the core
//
// Notes on behaviour
// - program counter is 21 bits held as low, high and upper bytes
// - low byte is software visible; high and upper change only via latches
// - writing the low byte loads both latches into the counter too
// - reading the low byte copies counter high and upper into the latches
// - counter bit 0 stays zero; sequential advance adds two
// - calls, jumps and branches load the counter directly, latches unused
// - call or interrupt pushes, every return pops; pushes and pops leave the latches alone unless a stack error reset clears them
// - 31 entries of 21 bits behind a 5-bit pointer, separate storage
// - push increments pointer first, then writes the counter there
// - pop loads counter from pointed entry, then decrements pointer
// - every reset clears the pointer; level zero has no entry
// - pointer and three top entry registers are software readable and writable
// - 31st push sets full flag; it stays until cleared or power-on
// - with error reset on, 31st push stores counter plus two and resets
// - with error reset off, pointer stays 31 and entry 31 is kept
// - pop on empty stack loads zero, sets underflow, pointer stays zero
// - full or underflow sets its flag, then resets if enabled
// - control register: full bit 7, underflow bit 6, bit 5 zero, level 4:0
// - explicit push increments pointer and stores current counter
// - explicit pop discards top entry by decrementing pointer
// - one-level shadows of status, working and bank select load on vectoring
// - fast return restores the three registers, fast call saves them
// - reset vector zero, high priority 0008h, low priority 0018h
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pc_stack_defines.vh"

module pc_return_stack (
    // clock and reset
    input wire CLK,
    input wire ARST_N,
    // ahb-lite slave
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    // operation from the instruction decoder and interrupt logic
    input wire [3:0] CORE_OP,
    input wire CORE_FAST,
    input wire [20:0] CORE_TARGET,
    input wire INT_HIGH,
    // current register values for the shadows
    input wire [7:0] STATUS_IN,
    input wire [7:0] WORKING_REG_IN,
    input wire [7:0] BANK_SELECT_REG_IN,
    // configuration and other device resets
    input wire STACK_ERROR_RESET_ENABLE,
    input wire SYS_RESET,
    // program counter and shadow outputs
    output wire [20:0] PC,
    output wire [7:0] STATUS_SHADOW,
    output wire [7:0] WORKING_REG_SHADOW,
    output wire [7:0] BANK_SELECT_REG_SHADOW,
    output wire RESTORE_STB,
    output wire DEV_RESET_REQ
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // step to the next instruction word; bit 0 is forced low
    function [20:0] pc_plus2;
        input [20:0] p;
        begin
            pc_plus2 = {p[20:1] + `PC_STEP, 1'b0};
        end
    endfunction

    // byte lane replace for the three top entry registers
    function [20:0] merge_byte;
        input [20:0] old;
        input [1:0] lane;
        input [7:0] val;
        begin
            case (lane)
                2'h0: merge_byte = {old[20:8], val};
                2'h1: merge_byte = {old[20:16], val, old[7:0]};
                default: merge_byte = {val[4:0], old[15:0]};
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [20:0] pc_q, pc_d;
    reg [7:0] high_latch_q, high_latch_d;
    reg [4:0] upper_latch_q, upper_latch_d;
    reg [4:0] level_q, level_d;
    reg full_q, full_d;
    reg underflow_q, underflow_d;
    reg err_reset_q;
    reg [7:0] status_sh_q, working_sh_q, bank_sh_q;
    reg dphase_q, ack_q, wr_q;
    reg [7:0] addr_q;
    reg [31:0] hrdata_q, rd_val;

    reg st_wr_en;
    reg [4:0] st_wr_idx;
    reg [20:0] st_wr_data;
    wire [20:0] top_entry;

    reg push_req, pop_req, discard_req, shadow_load;
    reg [20:0] pc_after;
    reg err_hit;

    // ------------------------------------------------------------
    // entry storage
    // ------------------------------------------------------------
    return_stack_store u_store (
        .clk(CLK),
        .arst_n(ARST_N),
        .wr_en(st_wr_en),
        .wr_idx(st_wr_idx),
        .wr_data(st_wr_data),
        .rd_idx(level_q),
        .rd_data(top_entry)
    );

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // one wait state or more: the access waits for a cycle with no core
    // op, so a flag set by the core never meets a software clear
    wire addr_take = HSEL & HTRANS[1] & HREADY;
    wire bus_do = dphase_q & ~ack_q & (CORE_OP == `OP_NONE);
    wire bus_wr = bus_do & wr_q;
    wire bus_rd = bus_do & ~wr_q;

    assign HREADYOUT = ~dphase_q | ack_q;
    assign HRESP = 1'b0; // always okay
    assign HRDATA = hrdata_q;

    // address phase capture and data phase progress
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dphase_q <= 1'b0;
            ack_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (HREADYOUT) begin
            dphase_q <= addr_take;
            ack_q <= 1'b0;
            // only whole words may write; other sizes are read-like
            wr_q <= HWRITE & (HSIZE == 3'h2);
            addr_q <= HADDR[7:0];
        end else if (bus_do) begin
            ack_q <= 1'b1;
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        rd_val = 32'h00000000;
        case (addr_q)
            `OFS_PC_LOW_BYTE: rd_val = {24'h000000, pc_q[7:0]};
            `OFS_PC_HIGH_LATCH: rd_val = {24'h000000, high_latch_q};
            `OFS_PC_UPPER_LATCH: rd_val = {27'h0000000, upper_latch_q};
            `OFS_STACK_CTL: rd_val = {24'h000000, full_q, underflow_q, 1'b0, level_q};
            `OFS_TOP_ENTRY_LOW: rd_val = {24'h000000, top_entry[7:0]};
            `OFS_TOP_ENTRY_HIGH: rd_val = {24'h000000, top_entry[15:8]};
            `OFS_TOP_ENTRY_UPPER: rd_val = {27'h0000000, top_entry[20:16]};
            default: rd_val = 32'h00000000;
        endcase
    end

    // read data is frozen in the wait cycle so it stands until ready
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hrdata_q <= 32'h00000000;
        end else if (bus_rd) begin
            hrdata_q <= rd_val;
        end
    end

    // ------------------------------------------------------------
    // core operation decode
    // ------------------------------------------------------------
    always @* begin
        push_req = 1'b0;
        pop_req = 1'b0;
        discard_req = 1'b0;
        shadow_load = 1'b0;
        pc_after = pc_q;
        case (CORE_OP)
            `OP_ADVANCE: begin
                pc_after = pc_plus2(pc_q);
            end
            `OP_JUMP: begin
                pc_after = {CORE_TARGET[20:1], 1'b0};
            end
            `OP_CALL: begin
                push_req = 1'b1;
                pc_after = {CORE_TARGET[20:1], 1'b0};
                shadow_load = CORE_FAST;
            end
            `OP_RETURN, `OP_EXIT_LITERAL, `OP_INTERRUPT_EXIT: begin
                pop_req = 1'b1;
            end
            `OP_INTERRUPT_ACK: begin
                push_req = 1'b1;
                shadow_load = 1'b1;
                pc_after = INT_HIGH ? `HIGH_PRIO_VECTOR : `LOW_PRIO_VECTOR;
            end
            `OP_PUSH: begin
                push_req = 1'b1;
            end
            `OP_POP: begin
                discard_req = 1'b1;
            end
            default: begin
                pc_after = pc_q;
            end
        endcase
    end

    // restore strobe for the status, working and bank select registers
    assign RESTORE_STB = CORE_FAST & ((CORE_OP == `OP_RETURN) ||
        (CORE_OP == `OP_INTERRUPT_EXIT));

    // ------------------------------------------------------------
    // next state of counter, latches, pointer and flags
    // ------------------------------------------------------------
    // core operations touch the latches only through a stack error reset, which clears them
    always @* begin
        pc_d = pc_q;
        high_latch_d = high_latch_q;
        upper_latch_d = upper_latch_q;
        level_d = level_q;
        full_d = full_q;
        underflow_d = underflow_q;
        st_wr_en = 1'b0;
        st_wr_idx = level_q;
        st_wr_data = pc_q;
        err_hit = 1'b0;
        if (push_req) begin
            pc_d = pc_after;
            if (level_q == `LEVEL_TOP) begin
                // overflow: entry 31 is kept and the pointer stays
                full_d = 1'b1;
                err_hit = STACK_ERROR_RESET_ENABLE;
            end else if (level_q == `LEVEL_BEFORE_FULL) begin
                st_wr_en = 1'b1;
                st_wr_idx = `LEVEL_TOP;
                full_d = 1'b1;
                level_d = `LEVEL_TOP;
                if (STACK_ERROR_RESET_ENABLE) begin
                    st_wr_data = pc_plus2(pc_q);
                    err_hit = 1'b1;
                end
            end else begin
                // increment first, then write the new top
                level_d = level_q + `LEVEL_STEP;
                st_wr_en = 1'b1;
                st_wr_idx = level_q + `LEVEL_STEP;
            end
        end else if (pop_req) begin
            if (level_q == `LEVEL_EMPTY) begin
                pc_d = `RESET_VECTOR;
                underflow_d = 1'b1;
                err_hit = STACK_ERROR_RESET_ENABLE;
            end else begin
                pc_d = {top_entry[20:1], 1'b0};
                level_d = level_q - `LEVEL_STEP;
            end
        end else if (discard_req) begin
            if (level_q == `LEVEL_EMPTY) begin
                underflow_d = 1'b1;
                err_hit = STACK_ERROR_RESET_ENABLE;
            end else begin
                level_d = level_q - `LEVEL_STEP;
            end
        end else begin
            pc_d = pc_after;
        end
        // software access, only in cycles without a core operation
        if (bus_wr) begin
            case (addr_q)
                `OFS_PC_LOW_BYTE: begin
                    pc_d = {upper_latch_q, high_latch_q, HWDATA[7:1], 1'b0};
                end
                `OFS_PC_HIGH_LATCH: begin
                    high_latch_d = HWDATA[7:0];
                end
                `OFS_PC_UPPER_LATCH: begin
                    upper_latch_d = HWDATA[4:0];
                end
                `OFS_STACK_CTL: begin
                    level_d = HWDATA[`LEVEL_MSB:`LEVEL_LSB];
                    full_d = full_q & HWDATA[`FULL_FLAG_BIT];
                    underflow_d = underflow_q & HWDATA[`UNDERFLOW_FLAG_BIT];
                end
                `OFS_TOP_ENTRY_LOW: begin
                    st_wr_en = 1'b1;
                    st_wr_data = merge_byte(top_entry, 2'h0, HWDATA[7:0]);
                end
                `OFS_TOP_ENTRY_HIGH: begin
                    st_wr_en = 1'b1;
                    st_wr_data = merge_byte(top_entry, 2'h1, HWDATA[7:0]);
                end
                `OFS_TOP_ENTRY_UPPER: begin
                    st_wr_en = 1'b1;
                    st_wr_data = merge_byte(top_entry, 2'h2, HWDATA[7:0]);
                end
                default: begin
                    st_wr_en = 1'b0;
                end
            endcase
        end
        if (bus_rd && (addr_q == `OFS_PC_LOW_BYTE)) begin
            high_latch_d = pc_q[15:8];
            upper_latch_d = pc_q[20:16];
        end
        // a device reset clears counter and pointer but keeps both flags
        if (err_hit || SYS_RESET) begin
            pc_d = `RESET_VECTOR;
            level_d = `LEVEL_EMPTY;
            high_latch_d = 8'h00;
            upper_latch_d = 5'h00;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // power-on reset is the only one that clears the flags
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_q <= `PC_RESET;
            high_latch_q <= 8'h00;
            upper_latch_q <= 5'h00;
            level_q <= `LEVEL_EMPTY;
            full_q <= 1'b0;
            underflow_q <= 1'b0;
            err_reset_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            high_latch_q <= high_latch_d;
            upper_latch_q <= upper_latch_d;
            level_q <= level_d;
            full_q <= full_d;
            underflow_q <= underflow_d;
            err_reset_q <= err_hit;
        end
    end

    // one-level shadows, loaded on vectoring or a fast call
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_sh_q <= 8'h00;
            working_sh_q <= 8'h00;
            bank_sh_q <= 8'h00;
        end else if (shadow_load) begin
            status_sh_q <= STATUS_IN;
            working_sh_q <= WORKING_REG_IN;
            bank_sh_q <= BANK_SELECT_REG_IN;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PC = pc_q;
    assign STATUS_SHADOW = status_sh_q;
    assign WORKING_REG_SHADOW = working_sh_q;
    assign BANK_SELECT_REG_SHADOW = bank_sh_q;
    assign DEV_RESET_REQ = err_reset_q;

endmodule // pc_return_stack

`default_nettype wire

// File: bench/pc_stack_assertions.sv
// concurrent checks on the ports of the pc and return stack block
`timescale 1ns/100ps
`default_nettype none
module pc_stack_checker (
    // clock and reset
    input wire CLK,
    input wire ARST_N,
    // bus
    input wire HSEL,
    input wire [1:0] HTRANS,
    input wire HREADY,
    input wire HREADYOUT,
    input wire HRESP,
    // core side
    input wire [3:0] CORE_OP,
    input wire CORE_FAST,
    input wire [20:0] CORE_TARGET,
    input wire INT_HIGH,
    input wire [7:0] STATUS_IN,
    input wire SYS_RESET,
    input wire STACK_ERROR_RESET_ENABLE,
    input wire [20:0] PC,
    input wire [7:0] STATUS_SHADOW,
    input wire RESTORE_STB,
    input wire DEV_RESET_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // ----------------------------------------
    // program counter and shadows
    // ----------------------------------------
    AST_PC_EVEN: assert property (PC[0] == 1'b0) else $error("pc odd");
    AST_ADVANCE: assert property ((CORE_OP == 4'h1 && !SYS_RESET) |=>
        PC == $past(PC) + 21'h2) else $error("advance wrong");
    AST_JUMP: assert property ((CORE_OP == 4'h2 && !SYS_RESET) |=>
        PC == {$past(CORE_TARGET[20:1]), 1'b0}) else $error("jump wrong");
    AST_VECTOR: assert property ((CORE_OP == 4'h7 && !SYS_RESET) |=> DEV_RESET_REQ ||
        PC == ($past(INT_HIGH) ? 21'h8 : 21'h18)) else $error("vector wrong");
    AST_SHADOW: assert property ((CORE_OP == 4'h7 || (CORE_OP == 4'h3 && CORE_FAST))
        |=> STATUS_SHADOW == $past(STATUS_IN)) else $error("shadow not loaded");
    AST_RESTORE: assert property (RESTORE_STB ==
        ((CORE_OP == 4'h4 || CORE_OP == 4'h6) && CORE_FAST)) else $error("restore wrong");
    // ----------------------------------------
    // resets and bus
    // ----------------------------------------
    AST_RST_PULSE: assert property (DEV_RESET_REQ |=> !DEV_RESET_REQ)
        else $error("reset request too long");
    AST_RST_CAUSE: assert property (DEV_RESET_REQ |-> PC == 21'h0 &&
        $past(STACK_ERROR_RESET_ENABLE)) else $error("reset request unexpected");
    AST_SYSRST: assert property (SYS_RESET |=> PC == 21'h0) else $error("pc kept");
    AST_WAIT: assert property ((HSEL && HTRANS[1] && HREADY) |=> !HREADYOUT)
        else $error("no wait cycle");
    AST_OKAY: assert property (HRESP == 1'b0) else $error("bad response");
endmodule // pc_stack_checker
bind pc_return_stack pc_stack_checker u_pc_stack_checker (.CLK(CLK), .ARST_N(ARST_N),
    .HSEL(HSEL), .HTRANS(HTRANS), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CORE_OP(CORE_OP), .CORE_FAST(CORE_FAST), .CORE_TARGET(CORE_TARGET),
    .INT_HIGH(INT_HIGH), .STATUS_IN(STATUS_IN), .SYS_RESET(SYS_RESET),
    .STACK_ERROR_RESET_ENABLE(STACK_ERROR_RESET_ENABLE), .PC(PC),
    .STATUS_SHADOW(STATUS_SHADOW), .RESTORE_STB(RESTORE_STB), .DEV_RESET_REQ(DEV_RESET_REQ));
`default_nettype wire

// File: bench/core_op_model.sv
// model of the decoder and interrupt logic driving the core op port
`timescale 1ns/100ps
`default_nettype none
module core_op_model (
    // clock
    input wire CLK,
    // operation request
    output logic [3:0] CORE_OP,
    output logic CORE_FAST,
    output logic [20:0] CORE_TARGET,
    output logic INT_HIGH,
    // live register values
    output logic [7:0] STATUS_IN,
    output logic [7:0] WORKING_REG_IN,
    output logic [7:0] BANK_SELECT_REG_IN
);
    // idle op and distinct register values at time zero
    initial begin
        CORE_OP = 4'h0;
        CORE_FAST = 1'b0;
        CORE_TARGET = 21'h0;
        INT_HIGH = 1'b0;
        STATUS_IN = 8'h5a;
        WORKING_REG_IN = 8'h3c;
        BANK_SELECT_REG_IN = 8'h0f;
    end
    // one op for one cycle; inputs move each call so a stale shadow shows;
    // interrupts never come while software touches the stack
    task automatic issue(input logic [3:0] op, input logic fast, input logic [20:0] tgt,
            input logic hi);
        @(posedge CLK);
        CORE_OP <= op;
        CORE_FAST <= fast;
        CORE_TARGET <= tgt;
        INT_HIGH <= hi;
        STATUS_IN <= STATUS_IN + 8'h13;
        WORKING_REG_IN <= WORKING_REG_IN + 8'h25;
        BANK_SELECT_REG_IN <= BANK_SELECT_REG_IN + 8'h07;
        @(posedge CLK);
        CORE_OP <= 4'h0;
        CORE_FAST <= ~fast;
        CORE_TARGET <= ~tgt; // stale, so show other bits
        #1;
    endtask
endmodule // core_op_model
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the pc and return stack block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic CLK = 1'b0, ARST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, SYS_RESET = 1'b0;
    logic STACK_ERROR_RESET_ENABLE = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, RESTORE_STB, DEV_RESET_REQ, CORE_FAST, INT_HIGH;
    wire [3:0] CORE_OP;
    wire [20:0] CORE_TARGET, PC;
    wire [7:0] STATUS_IN, WORKING_REG_IN, BANK_SELECT_REG_IN;
    wire [7:0] STATUS_SHADOW, WORKING_REG_SHADOW, BANK_SELECT_REG_SHADOW;
    int err_count = 0;
    int tests_run = 0;
    always #5 CLK = ~CLK;
    pc_return_stack u_pc_return_stack (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .CORE_OP(CORE_OP), .CORE_FAST(CORE_FAST), .CORE_TARGET(CORE_TARGET),
        .INT_HIGH(INT_HIGH), .STATUS_IN(STATUS_IN), .WORKING_REG_IN(WORKING_REG_IN),
        .BANK_SELECT_REG_IN(BANK_SELECT_REG_IN),
        .STACK_ERROR_RESET_ENABLE(STACK_ERROR_RESET_ENABLE), .SYS_RESET(SYS_RESET),
        .PC(PC), .STATUS_SHADOW(STATUS_SHADOW), .WORKING_REG_SHADOW(WORKING_REG_SHADOW),
        .BANK_SELECT_REG_SHADOW(BANK_SELECT_REG_SHADOW), .RESTORE_STB(RESTORE_STB),
        .DEV_RESET_REQ(DEV_RESET_REQ));
    core_op_model u_core_op_model (.CLK(CLK), .CORE_OP(CORE_OP), .CORE_FAST(CORE_FAST),
        .CORE_TARGET(CORE_TARGET), .INT_HIGH(INT_HIGH), .STATUS_IN(STATUS_IN),
        .WORKING_REG_IN(WORKING_REG_IN), .BANK_SELECT_REG_IN(BANK_SELECT_REG_IN));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for hready, sampled at each edge
    task automatic wait_ready();
        int n = 0;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) begin
            n++;
            if (n > 40) begin
                err_count++;
                $display("[ERR] %0t bus timeout", $time);
                summarize();
            end
            @(posedge CLK);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        wait_ready();
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_ready();
        if (!w) check(HRDATA, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, e);
    endtask
    task automatic pcchk(input logic [20:0] e);
        check({11'h0, PC}, {11'h0, e});
    endtask
    task automatic op(input logic [3:0] o, input logic f = 1'b0, input logic [20:0] t = 0,
            input logic hi = 1'b0);
        u_core_op_model.issue(o, f, t, hi);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_latches();
        rdchk(8'h0c, 32'h0);
        rdchk(8'h1c, 32'h0);
        wr(8'h04, 32'h12);
        wr(8'h08, 32'h1b);
        wr(8'h00, 32'h57);
        pcchk(21'h1b1256);
        op(4'h2, 1'b0, 21'h0abcd5);
        pcchk(21'h0abcd4);
        rdchk(8'h04, 32'h12);
        rdchk(8'h00, 32'hd4);
        rdchk(8'h04, 32'hbc);
        rdchk(8'h08, 32'h0a);
        op(4'h1);
        pcchk(21'h0abcd6);
    endtask
    task automatic s_call();
        wr(8'h04, 32'h33);
        op(4'h3, 1'b0, 21'h000100);
        rdchk(8'h0c, 32'h01);
        rdchk(8'h10, 32'hd6);
        rdchk(8'h14, 32'hbc);
        rdchk(8'h18, 32'h0a);
        wr(8'h10, 32'h20);
        op(4'h4);
        pcchk(21'h0abc20);
        rdchk(8'h0c, 32'h0);
        rdchk(8'h04, 32'h33);
        for (int o = 5; o < 7; o++) begin
            op(4'h3, 1'b0, 21'h000200);
            op(o[3:0]);
            pcchk(21'h0abc20);
        end
    endtask
    task automatic s_underflow();
        op(4'h4);
        pcchk(21'h0);
        rdchk(8'h0c, 32'h40);
        rdchk(8'h04, 32'h33);
        wr(8'h0c, 32'h40);
        rdchk(8'h0c, 32'h40);
        wr(8'h0c, 32'h00);
        rdchk(8'h0c, 32'h0);
    endtask
    // pc runs 2, 4, ... so push k stores 2k
    task automatic s_full();
        repeat (31) begin
            op(4'h1);
            op(4'h8);
        end
        rdchk(8'h0c, 32'h9f);
        rdchk(8'h10, 32'h3e);
        op(4'h1);
        op(4'h8);
        rdchk(8'h0c, 32'h9f);
        rdchk(8'h10, 32'h3e);
        op(4'h9);
        rdchk(8'h0c, 32'h9e);
        rdchk(8'h10, 32'h3c);
        @(posedge CLK);
        SYS_RESET <= 1'b1;
        @(posedge CLK);
        SYS_RESET <= 1'b0;
        #1;
        pcchk(21'h0);
        rdchk(8'h0c, 32'h80);
        wr(8'h0c, 32'h00);
    endtask
    task automatic s_err_reset();
        @(posedge CLK);
        STACK_ERROR_RESET_ENABLE <= 1'b1;
        wr(8'h0c, 32'h1e);
        op(4'h2, 1'b0, 21'h001234);
        op(4'h8);
        check({31'h0, DEV_RESET_REQ}, 32'h1);
        pcchk(21'h0);
        rdchk(8'h0c, 32'h80);
        wr(8'h0c, 32'h9f);
        rdchk(8'h10, 32'h36);
        rdchk(8'h14, 32'h12);
        wr(8'h0c, 32'h00);
        op(4'h4);
        check({31'h0, DEV_RESET_REQ}, 32'h1);
        rdchk(8'h0c, 32'h40);
        @(posedge CLK);
        STACK_ERROR_RESET_ENABLE <= 1'b0;
        wr(8'h0c, 32'h00);
    endtask
    task automatic s_fast();
        op(4'h7, 1'b0, 21'h0, 1'b1);
        pcchk(21'h8);
        check({24'h0, WORKING_REG_SHADOW}, {24'h0, WORKING_REG_IN});
        op(4'h7, 1'b0, 21'h0, 1'b0);
        pcchk(21'h18);
        check({24'h0, BANK_SELECT_REG_SHADOW}, {24'h0, BANK_SELECT_REG_IN});
        op(4'h6, 1'b1);
        pcchk(21'h8);
        op(4'h3, 1'b1, 21'h000040);
        check({24'h0, STATUS_SHADOW}, {24'h0, STATUS_IN});
        op(4'h4, 1'b1);
        pcchk(21'h8);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        s_latches();
        s_call();
        s_underflow();
        s_full();
        s_err_reset();
        s_fast();
        summarize();
    end
endmodule // testbench
`default_nettype wire
